// File: src/tmr_pkg.sv
/*
 Constants shared by the rate and limit register block: pointers, reset
 values, field layout, sequencer states and timing.
 Assumes a single 125 MHz clock and the documented pointer map.
*/
// Functional notes
// - Rate field selects 1/16 s up to 32/s
// - Rate changes idle gap, not conversion time
// - Rate register resets to 08h
// - Rate read at 04h, written at 0Ah
// - Local high limit 05h/0Bh, resets 55h
// - Local low limit 06h/0Ch, resets 00h
// - Local result compared against high limit
// - Local result compared against low limit
// - Remote high upper 07h/0Dh, resets 55h
// - Remote low upper 08h/0Eh, resets 00h
// - Remote high upper is threshold integer part
// - Remote low upper is threshold integer part
// - Trigger at 0Fh starts one conversion in shutdown
// - Shutdown stops after current conversion, clear resumes
// - Remote over-limit flag when result exceeds limit
package tmr_pkg;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_LOC_HI = 8'h05;
	localparam logic [7:0] RD_LOC_LO = 8'h06;
	localparam logic [7:0] RD_REM_HI = 8'h07;
	localparam logic [7:0] RD_REM_LO = 8'h08;
	localparam logic [7:0] WR_RATE = 8'h0a;
	localparam logic [7:0] WR_LOC_HI = 8'h0b;
	localparam logic [7:0] WR_LOC_LO = 8'h0c;
	localparam logic [7:0] WR_REM_HI = 8'h0d;
	localparam logic [7:0] WR_REM_LO = 8'h0e;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
	localparam logic [3:0] RATE_RESET = 4'h8;
	localparam logic [3:0] RATE_MAX = 4'h9;
	localparam logic [7:0] LOC_HI_RESET = 8'h55;
	localparam logic [7:0] LOC_LO_RESET = 8'h00;
	localparam logic [7:0] REM_HI_RESET = 8'h55;
	localparam logic [7:0] REM_LO_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam logic [3:0] RATE_PAD = 4'h0;
	localparam logic [3:0] FRAC_ZERO = 4'h0;
	// Temperature word: integer byte is bits 11..4
	localparam int TEMP_W = 12;
	localparam int FRAC_W = 4;
	localparam longint CLK_HZ = 125000000;
	localparam longint SLOW_PERIOD_S = 16;
	localparam longint SLOW_CYCLES = SLOW_PERIOD_S * CLK_HZ;
	localparam longint CONV_TIME_US = 10;
	localparam longint CONV_CYCLES = (CONV_TIME_US * CLK_HZ) / 1000000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_WAIT = 2'b10
	} tmr_state_t;
endpackage

// File: src/tmr_rate_timer.sv
/*
 Idle-interval timer between conversions.
 Assumes load arrives as a one-cycle pulse at conversion end.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_rate_timer #(
	parameter int unsigned SLOW_CYCLES = 32'd2000000000,
	parameter int unsigned CONV_CYCLES = 32'd1250
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [3:0] rateCode,
	// Status
	output logic expired
);
	logic [31:0] cnt_q;
	logic running_q;
	wire [31:0] period = SLOW_CYCLES >> rateCode;
	wire [31:0] idle = (period > CONV_CYCLES) ? period - CONV_CYCLES : 32'd1;
	assign expired = running_q && (cnt_q == 32'd1);
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_q <= 32'd0;
			running_q <= 1'b0;
		end else if (load) begin
			cnt_q <= idle;
			running_q <= 1'b1;
		end else if (expired) begin
			running_q <= 1'b0;
		end else if (running_q) begin
			cnt_q <= cnt_q - 32'd1;
		end
	end
endmodule // tmr_rate_timer
`default_nettype wire

// File: src/tmr_limit_cmp.sv
/*
 Compares one temperature word with a high and low limit.
 Assumes the result is an unsigned 12-bit word with a valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_limit_cmp #(
	parameter int TW = 12,
	parameter int FW = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Measurement
	input wire logic [TW-1:0] temp,
	input wire logic tempValid,
	// Limits: integer byte plus fraction
	input wire logic [TW-FW-1:0] hiLimit,
	input wire logic [FW-1:0] hiFrac,
	input wire logic [TW-FW-1:0] loLimit,
	input wire logic [FW-1:0] loFrac,
	// Results
	output logic over_q,
	output logic under_q
);
	wire isOver = temp > {hiLimit, hiFrac};
	wire isUnder = temp < {loLimit, loFrac};
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			over_q <= 1'b0;
			under_q <= 1'b0;
		end else if (tempValid) begin
			over_q <= isOver;
			under_q <= isUnder;
		end
	end
endmodule // tmr_limit_cmp
`default_nettype wire

// File: src/tmr_rate_limit_regs.sv
/*
 Conversion rate, local limits, remote limit upper bytes and the one-shot
 trigger, with the conversion sequencer they steer.
 Assumes a register port already decoded from the serial interface and
 ADC results delivered with one-cycle valid strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_rate_limit_regs #(
	parameter int unsigned SLOW_CYCLES = 32'(tmr_pkg::SLOW_CYCLES),
	parameter int unsigned CONV_CYCLES = 32'(tmr_pkg::CONV_CYCLES)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register write port
	input wire logic wrStb,
	input wire logic [7:0] wrPtr,
	input wire logic [7:0] wrData,
	// Register read port
	input wire logic rdStb,
	input wire logic [7:0] rdPtr,
	output logic [7:0] rdData_q,
	output logic rdAck_q,
	// Configuration
	input wire logic shutdownControlBit,
	// Measurements and remote limit fractions
	input wire logic [11:0] localTemp,
	input wire logic localValid,
	input wire logic [11:0] remoteTemp,
	input wire logic remoteValid,
	input wire logic [3:0] remoteHighFrac,
	input wire logic [3:0] remoteLowFrac,
	// Sequencer
	output logic convStart,
	output logic converting,
	// Comparator results
	output logic localOver_q,
	output logic localUnder_q,
	output logic remoteOverLimitFlag_q,
	output logic remoteUnder_q
);
	logic [3:0] rateSelectField_q;
	logic [7:0] localHighLimitBits_q;
	logic [7:0] localLowLimitBits_q;
	logic [7:0] remoteHighLimitUpperBits_q;
	logic [7:0] remoteLowLimitUpperBits_q;
	logic oneShotPending_q;
	logic [31:0] convCnt_q;
	tmr_pkg::tmr_state_t state_q;
	tmr_pkg::tmr_state_t state_d;

	// Write decode, read-only pointers never write
	wire wrRate = wrStb && (wrPtr == tmr_pkg::WR_RATE);
	wire wrLocHi = wrStb && (wrPtr == tmr_pkg::WR_LOC_HI);
	wire wrLocLo = wrStb && (wrPtr == tmr_pkg::WR_LOC_LO);
	wire wrRemHi = wrStb && (wrPtr == tmr_pkg::WR_REM_HI);
	wire wrRemLo = wrStb && (wrPtr == tmr_pkg::WR_REM_LO);
	// Trigger counts only in shutdown
	wire wrOneShot = wrStb && (wrPtr == tmr_pkg::WR_ONE_SHOT) && shutdownControlBit;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rateSelectField_q <= tmr_pkg::RATE_RESET;
			localHighLimitBits_q <= tmr_pkg::LOC_HI_RESET;
			localLowLimitBits_q <= tmr_pkg::LOC_LO_RESET;
			remoteHighLimitUpperBits_q <= tmr_pkg::REM_HI_RESET;
			remoteLowLimitUpperBits_q <= tmr_pkg::REM_LO_RESET;
		end else begin
			if (wrRate) begin
				rateSelectField_q <= wrData[3:0];
			end
			if (wrLocHi) begin
				localHighLimitBits_q <= wrData;
			end
			if (wrLocLo) begin
				localLowLimitBits_q <= wrData;
			end
			if (wrRemHi) begin
				remoteHighLimitUpperBits_q <= wrData;
			end
			if (wrRemLo) begin
				remoteLowLimitUpperBits_q <= wrData;
			end
		end
	end

	// Read mux, unmapped and write-only pointers read zero
	wire [7:0] rdMux =
		(rdPtr == tmr_pkg::RD_RATE) ? {tmr_pkg::RATE_PAD, rateSelectField_q} :
		(rdPtr == tmr_pkg::RD_LOC_HI) ? localHighLimitBits_q :
		(rdPtr == tmr_pkg::RD_LOC_LO) ? localLowLimitBits_q :
		(rdPtr == tmr_pkg::RD_REM_HI) ? remoteHighLimitUpperBits_q :
		(rdPtr == tmr_pkg::RD_REM_LO) ? remoteLowLimitUpperBits_q :
		tmr_pkg::READ_NONE;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdData_q <= tmr_pkg::READ_NONE;
			rdAck_q <= 1'b0;
		end else begin
			rdAck_q <= rdStb;
			if (rdStb) begin
				rdData_q <= rdMux;
			end
		end
	end

	// Undefined codes run at the fastest rate
	wire [3:0] rateEff = (rateSelectField_q > tmr_pkg::RATE_MAX) ?
		tmr_pkg::RATE_MAX : rateSelectField_q;

	// Sequencer
	wire convDone = (state_q == tmr_pkg::ST_CONV) && (convCnt_q == CONV_CYCLES - 32'd1);
	wire idleDone;
	wire convLoad = convDone && !shutdownControlBit;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tmr_pkg::ST_IDLE: begin
				if (!shutdownControlBit || oneShotPending_q) begin
					state_d = tmr_pkg::ST_CONV;
				end
			end
			tmr_pkg::ST_CONV: begin
				if (convDone) begin
					// Finish the sequence, then honour shutdown
					state_d = shutdownControlBit ? tmr_pkg::ST_IDLE : tmr_pkg::ST_WAIT;
				end
			end
			tmr_pkg::ST_WAIT: begin
				if (shutdownControlBit) begin
					state_d = tmr_pkg::ST_IDLE;
				end else if (idleDone) begin
					state_d = tmr_pkg::ST_CONV;
				end
			end
			default: begin
				state_d = tmr_pkg::ST_IDLE;
			end
		endcase
	end

	// No start pulse while reset holds the sequencer
	assign convStart = reset_n && (state_q != tmr_pkg::ST_CONV) &&
		(state_d == tmr_pkg::ST_CONV);
	assign converting = (state_q == tmr_pkg::ST_CONV);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= tmr_pkg::ST_IDLE;
			convCnt_q <= 32'd0;
		end else begin
			state_q <= state_d;
			convCnt_q <= convStart ? 32'd0 : convCnt_q + 32'd1;
		end
	end

	// Pending trigger; a new write wins over the clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			oneShotPending_q <= 1'b0;
		end else if (wrOneShot) begin
			oneShotPending_q <= 1'b1;
		end else if (convStart || !shutdownControlBit) begin
			oneShotPending_q <= 1'b0;
		end
	end

	tmr_rate_timer #(
		.SLOW_CYCLES(SLOW_CYCLES),
		.CONV_CYCLES(CONV_CYCLES)
	) uTimer (
		.clock(clock),
		.reset_n(reset_n),
		.load(convLoad),
		.rateCode(rateEff),
		.expired(idleDone)
	);

	tmr_limit_cmp #(
		.TW(tmr_pkg::TEMP_W),
		.FW(tmr_pkg::FRAC_W)
	) uLocalCmp (
		.clock(clock),
		.reset_n(reset_n),
		.temp(localTemp),
		.tempValid(localValid),
		.hiLimit(localHighLimitBits_q),
		.hiFrac(tmr_pkg::FRAC_ZERO),
		.loLimit(localLowLimitBits_q),
		.loFrac(tmr_pkg::FRAC_ZERO),
		.over_q(localOver_q),
		.under_q(localUnder_q)
	);

	tmr_limit_cmp #(
		.TW(tmr_pkg::TEMP_W),
		.FW(tmr_pkg::FRAC_W)
	) uRemoteCmp (
		.clock(clock),
		.reset_n(reset_n),
		.temp(remoteTemp),
		.tempValid(remoteValid),
		.hiLimit(remoteHighLimitUpperBits_q),
		.hiFrac(remoteHighFrac),
		.loLimit(remoteLowLimitUpperBits_q),
		.loFrac(remoteLowFrac),
		.over_q(remoteOverLimitFlag_q),
		.under_q(remoteUnder_q)
	);

	// Checks
	property p_rate_reset;
		@(posedge clock) !reset_n |=> rateSelectField_q == tmr_pkg::RATE_RESET;
	endproperty
	a_rate_reset: assert property (p_rate_reset) else $error("rate reset wrong");

	property p_rate_pad;
		@(posedge clock) disable iff (!reset_n)
		rdStb && rdPtr == tmr_pkg::RD_RATE |=> rdData_q[7:4] == tmr_pkg::RATE_PAD && rdAck_q;
	endproperty
	a_rate_pad: assert property (p_rate_pad) else $error("rate upper nibble set");

	property p_rate_write;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::WR_RATE |=> rateSelectField_q == $past(wrData[3:0]);
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("rate write lost");

	property p_loc_hi_ro;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::RD_LOC_HI |=> $stable(localHighLimitBits_q);
	endproperty
	a_loc_hi_ro: assert property (p_loc_hi_ro) else $error("read pointer wrote");

	property p_rem_hi_rd;
		@(posedge clock) disable iff (!reset_n)
		rdStb && rdPtr == tmr_pkg::RD_REM_HI |=> rdData_q == $past(remoteHighLimitUpperBits_q);
	endproperty
	a_rem_hi_rd: assert property (p_rem_hi_rd) else $error("remote high read wrong");

	property p_conv_len;
		@(posedge clock) disable iff (!reset_n)
		convStart |=> converting && convCnt_q == 32'd0;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion not started");

	property p_sd_quiet;
		@(posedge clock) disable iff (!reset_n)
		shutdownControlBit && state_q == tmr_pkg::ST_IDLE && !oneShotPending_q && !wrOneShot
		|=> !converting;
	endproperty
	a_sd_quiet: assert property (p_sd_quiet) else $error("converting in shutdown");

	property p_one_shot;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::WR_ONE_SHOT && shutdownControlBit && state_q == tmr_pkg::ST_IDLE
		|=> ##[0:1] convStart;
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("one-shot not started");

	property p_rem_over;
		@(posedge clock) disable iff (!reset_n)
		remoteValid |=> remoteOverLimitFlag_q ==
			($past(remoteTemp) > {$past(remoteHighLimitUpperBits_q), $past(remoteHighFrac)});
	endproperty
	a_rem_over: assert property (p_rem_over) else $error("remote over flag wrong");

	property p_loc_lo_write;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::WR_LOC_LO |=> localLowLimitBits_q == $past(wrData);
	endproperty
	a_loc_lo_write: assert property (p_loc_lo_write) else $error("local low write lost");

	property p_rem_lo_write;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::WR_REM_LO |=> remoteLowLimitUpperBits_q == $past(wrData);
	endproperty
	a_rem_lo_write: assert property (p_rem_lo_write) else $error("remote low write lost");

	property p_loc_over;
		@(posedge clock) disable iff (!reset_n)
		localValid |=> localOver_q ==
			($past(localTemp) > {$past(localHighLimitBits_q), tmr_pkg::FRAC_ZERO});
	endproperty
	a_loc_over: assert property (p_loc_over) else $error("local over flag wrong");

	property p_loc_under;
		@(posedge clock) disable iff (!reset_n)
		localValid |=> localUnder_q ==
			($past(localTemp) < {$past(localLowLimitBits_q), tmr_pkg::FRAC_ZERO});
	endproperty
	a_loc_under: assert property (p_loc_under) else $error("local under flag wrong");

	property p_rem_under;
		@(posedge clock) disable iff (!reset_n)
		remoteValid |=> remoteUnder_q ==
		($past(remoteTemp) < {$past(remoteLowLimitUpperBits_q), $past(remoteLowFrac)});
	endproperty
	a_rem_under: assert property (p_rem_under) else $error("remote under flag wrong");

	property p_trig_ignored;
		@(posedge clock) disable iff (!reset_n)
		wrStb && wrPtr == tmr_pkg::WR_ONE_SHOT && !shutdownControlBit
		|=> !oneShotPending_q;
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");
endmodule // tmr_rate_limit_regs
`default_nettype wire

// File: bench/tmr_host_model.sv
/*
 Host side of the register port: byte writes and reads by pointer.
 Assumes the device takes a strobe on a rising edge and answers reads one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
	// Clock
	input wire logic clock,
	// Write port
	output logic wrStb,
	output logic [7:0] wrPtr,
	output logic [7:0] wrData,
	// Read port
	output logic rdStb,
	output logic [7:0] rdPtr,
	input wire logic [7:0] rdData_q,
	input wire logic rdAck_q
);
	initial begin
		wrStb = 1'b0;
		rdStb = 1'b0;
		wrPtr = 8'h00;
		wrData = 8'h00;
		rdPtr = 8'h00;
	end

	// Write pointers only for writes
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
		@(negedge clock);
		wrPtr = ptr;
		wrData = data;
		wrStb = 1'b1;
		@(negedge clock);
		wrStb = 1'b0;
		wrPtr = ~ptr;
		wrData = ~data;
	endtask

	// Read pointers only for reads; answer sampled after the taking edge
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		@(negedge clock);
		rdPtr = ptr;
		rdStb = 1'b1;
		@(negedge clock);
		d = rdData_q;
		ok = rdAck_q;
		rdStb = 1'b0;
		rdPtr = ~ptr;
	endtask
endmodule // tmr_host_model
`default_nettype wire

// File: bench/tb_top.sv
/*
 Self-checking bench for the rate and limit register block.
 Assumes shortened timing: 8192 cycles for the slowest rate, 8 per conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock, reset_n, shutdownControlBit, localValid, remoteValid;
	logic wrStb, rdStb, rdAck_q, convStart, converting;
	logic [7:0] wrPtr, wrData, rdPtr, rdData_q;
	logic [11:0] localTemp, remoteTemp;
	logic localOver_q, localUnder_q, remoteOverLimitFlag_q, remoteUnder_q;
	logic [3:0] remHiFrac, remLoFrac;
	int error_cnt = 0;
	int cmp_count = 0;

	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end

	tmr_rate_limit_regs #(.SLOW_CYCLES(8192), .CONV_CYCLES(8)) dut_u (.clock(clock),
		.reset_n(reset_n), .wrStb(wrStb), .wrPtr(wrPtr), .wrData(wrData), .rdStb(rdStb),
		.rdPtr(rdPtr), .rdData_q(rdData_q), .rdAck_q(rdAck_q),
		.shutdownControlBit(shutdownControlBit), .localTemp(localTemp),
		.localValid(localValid), .remoteTemp(remoteTemp), .remoteValid(remoteValid),
		.remoteHighFrac(remHiFrac), .remoteLowFrac(remLoFrac), .convStart(convStart),
		.converting(converting), .localOver_q(localOver_q), .localUnder_q(localUnder_q),
		.remoteOverLimitFlag_q(remoteOverLimitFlag_q), .remoteUnder_q(remoteUnder_q));

	tmr_host_model host_u (.clock(clock), .wrStb(wrStb), .wrPtr(wrPtr), .wrData(wrData),
		.rdStb(rdStb), .rdPtr(rdPtr), .rdData_q(rdData_q), .rdAck_q(rdAck_q));

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host_u.read_reg(ptr, d, ok);
		check({7'h00, ok}, 8'h01);
		check(d, exp);
	endtask

	// Bounded wait for a conversion start
	task automatic wait_start;
		int i;
		for (i = 0; i < 300 && convStart !== 1'b1; i++) @(negedge clock);
		if (convStart !== 1'b1) begin
			error_cnt++;
			wrap_up();
		end
	endtask

	task automatic period(output int p, output int w);
		wait_start();
		p = 0;
		w = 0;
		do begin
			@(negedge clock);
			p++;
			w += int'(converting === 1'b1);
		end while (convStart !== 1'b1 && p < 300);
		if (convStart !== 1'b1) begin
			error_cnt++;
			wrap_up();
		end
	endtask

	task automatic count_starts(output int n);
		n = 0;
		// Sample the current cycle first: a start may already be showing
		repeat (100) begin
			n += int'(convStart === 1'b1);
			@(negedge clock);
		end
	endtask

	task automatic t_reset;
		logic [7:0] e [5] = '{8'h08, 8'h55, 8'h00, 8'h55, 8'h00};
		for (int i = 0; i < 5; i++) rd_chk(8'h04 + 8'(i), e[i]);
	endtask

	task automatic t_regs;
		host_u.write_reg(8'h0b, 8'h30);
		host_u.write_reg(8'h0c, 8'h10);
		host_u.write_reg(8'h0d, 8'h40);
		host_u.write_reg(8'h0e, 8'h20);
		host_u.write_reg(8'h0a, 8'hf9);
		host_u.write_reg(8'h04, 8'h77);
		host_u.write_reg(8'h05, 8'haa);
		rd_chk(8'h05, 8'h30);
		rd_chk(8'h06, 8'h10);
		rd_chk(8'h07, 8'h40);
		rd_chk(8'h08, 8'h20);
		rd_chk(8'h04, 8'h09);
		rd_chk(8'h0a, 8'h00);
		rd_chk(8'h0f, 8'h00);
	endtask

	task automatic t_rate;
		int p8, p9, w8, w9;
		host_u.write_reg(8'h0a, 8'h0c);
		rd_chk(8'h04, 8'h0c);
		period(p9, w9);
		period(p9, w9);
		check(8'(p9), 8'h10);
		host_u.write_reg(8'h0a, 8'h08);
		period(p8, w8);
		period(p8, w8);
		check(8'(p8), 8'h20);
		check(8'(p8 - p9), 8'h10);
		check(8'(w8), 8'h08);
		check(8'(w9), 8'h08);
	endtask

	task automatic t_shut;
		int n;
		wait_start();
		host_u.write_reg(8'h0f, 8'h5a);
		shutdownControlBit = 1;
		count_starts(n);
		check(8'(n), 8'h00);
		host_u.write_reg(8'h0f, 8'h00);
		count_starts(n);
		check(8'(n), 8'h01);
		shutdownControlBit = 0;
		count_starts(n);
		check(8'(n > 0), 8'h01);
	endtask

	task automatic meas(input logic [11:0] l, input logic [11:0] r, input logic [3:0] exp);
		localTemp = l;
		remoteTemp = r;
		localValid = 1;
		remoteValid = 1;
		@(negedge clock);
		localValid = 0;
		remoteValid = 0;
		@(negedge clock);
		check({4'h0, localOver_q, localUnder_q, remoteOverLimitFlag_q, remoteUnder_q},
			{4'h0, exp});
	endtask

	initial begin
		reset_n = 1'b0;
		shutdownControlBit = 1'b0;
		localValid = 1'b0;
		remoteValid = 1'b0;
		localTemp = 12'h000;
		remoteTemp = 12'h000;
		remHiFrac = 4'h0;
		remLoFrac = 4'h0;
		repeat (16) @(negedge clock);
		reset_n = 1'b1;
		t_reset();
		t_regs();
		t_rate();
		t_shut();
		meas(12'h310, 12'h401, 4'b1010);
		meas(12'h300, 12'h400, 4'b0000);
		meas(12'h0ff, 12'h1ff, 4'b0101);
		remHiFrac = 4'h8;
		remLoFrac = 4'h8;
		meas(12'h300, 12'h408, 4'b0000);
		meas(12'h300, 12'h409, 4'b0010);
		meas(12'h300, 12'h207, 4'b0001);
		// Second reset after the registers were rewritten
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		t_reset();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
